//--- inc/urxq_pkg.sv
// Shared constants and types for the receive queue channel.
package urxq_pkg;
  // Register addresses on the host bus.
  localparam logic [3:0] URXQ_ADDR_MODE = 4'h0;
  localparam logic [3:0] URXQ_ADDR_STATUS = 4'h1;
  localparam logic [3:0] URXQ_ADDR_CMD = 4'h2;
  localparam logic [3:0] URXQ_ADDR_HOLD = 4'h3;
  // First mode register fields and reset value.
  localparam int URXQ_MR_RTS_BIT = 7;
  localparam int URXQ_MR_INTSEL_BIT = 6;
  localparam int URXQ_MR_ERRMODE_BIT = 5;
  localparam int URXQ_MR_PMODE_HI = 4;
  localparam int URXQ_MR_PMODE_LO = 3;
  localparam int URXQ_MR_PTYPE_BIT = 2;
  localparam int URXQ_MR_LEN_HI = 1;
  localparam int URXQ_MR_LEN_LO = 0;
  localparam logic [7:0] URXQ_MR_RESET = 8'h00;
  // Parity mode encodings.
  localparam logic [1:0] URXQ_PM_WITH = 2'h0;
  localparam logic [1:0] URXQ_PM_FORCE = 2'h1;
  localparam logic [1:0] URXQ_PM_NONE = 2'h2;
  localparam logic [1:0] URXQ_PM_MDROP = 2'h3;
  localparam logic [2:0] URXQ_LEN_BASE = 3'h5;
  // Command register fields and miscellaneous commands.
  localparam int URXQ_CMD_RXEN_BIT = 0;
  localparam int URXQ_CMD_RXDIS_BIT = 1;
  localparam int URXQ_CMD_MISC_HI = 6;
  localparam int URXQ_CMD_MISC_LO = 4;
  localparam logic [2:0] URXQ_MISC_RST_PTR = 3'h1;
  localparam logic [2:0] URXQ_MISC_RST_RX = 3'h2;
  localparam logic [2:0] URXQ_MISC_RST_ERR = 3'h4;
  // Status register positions.
  localparam int URXQ_STAT_BRK_BIT = 7;
  localparam int URXQ_STAT_FRM_BIT = 6;
  localparam int URXQ_STAT_PERR_BIT = 5;
  localparam int URXQ_STAT_OVR_BIT = 4;
  localparam int URXQ_STAT_FULL_BIT = 1;
  localparam int URXQ_STAT_RDY_BIT = 0;
  // Queue geometry: an entry is {break, framing, parity, data}.
  localparam int URXQ_DEPTH = 3;
  localparam int URXQ_ENTRY_W = 11;
  localparam logic [1:0] URXQ_DEPTH_CNT = 2'h3;
  // Sample timing in ticks of the 16x bit clock.
  localparam logic [3:0] URXQ_HALF_TICKS = 4'h8;
  localparam logic [3:0] URXQ_BIT_TICKS = 4'hF;
  typedef enum logic [6:0] {
    URXQ_IDLE = 7'h01,
    URXQ_START = 7'h02,
    URXQ_DATA = 7'h04,
    URXQ_PAR = 7'h08,
    URXQ_STOP = 7'h10,
    URXQ_BRKW = 7'h20,
    URXQ_FEW = 7'h40
  } urxq_state_t;
endpackage

//--- inc/urxq_q_if.sv
// Carrier between the receiver core and its holding queue.
`timescale 1ns/10ps
interface urxq_q_if;
  logic clr;
  logic push;
  logic [10:0] push_data;
  logic pop;
  logic [10:0] head;
  logic full;
  logic empty;
  logic [1:0] cnt;
  modport wr (output clr, push, push_data, pop, input head, full, empty, cnt);
  modport q (input clr, push, push_data, pop, output head, full, empty, cnt);
endinterface

//--- core/urxq_fifo.sv
// Three-entry holding queue of characters with their error tags.
`timescale 1ns/10ps
module urxq_fifo (
  // Clock, reset and enable.
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Queue port.
  urxq_q_if.q qp
);
  import urxq_pkg::*;
  logic [10:0] mem [0:2];
  logic [1:0] rd_ptr_r;
  logic [1:0] wr_ptr_r;
  logic [1:0] cnt_r;
  logic do_push;
  logic do_pop;

  function automatic logic [1:0] ptr_inc(input logic [1:0] p);
    ptr_inc = (p == 2'h2) ? 2'h0 : p + 2'h1;
  endfunction

  assign do_push = qp.push && (cnt_r != URXQ_DEPTH_CNT);
  assign do_pop = qp.pop && (cnt_r != 2'h0);

  always_ff @(posedge ref_clk_i) begin
    if (ce_i && do_push && !qp.clr) begin
      mem[wr_ptr_r] <= qp.push_data;
    end
  end

  // Data and tags leave together, one position per read.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_ptr_r <= 2'h0;
      wr_ptr_r <= 2'h0;
      cnt_r <= 2'h0;
    end else if (ce_i) begin
      if (qp.clr) begin
        rd_ptr_r <= 2'h0;
        wr_ptr_r <= 2'h0;
        cnt_r <= 2'h0;
      end else begin
        if (do_push) begin
          wr_ptr_r <= ptr_inc(wr_ptr_r);
        end
        if (do_pop) begin
          rd_ptr_r <= ptr_inc(rd_ptr_r);
        end
        if (do_push && !do_pop) begin
          cnt_r <= cnt_r + 2'h1;
        end else if (do_pop && !do_push) begin
          cnt_r <= cnt_r - 2'h1;
        end
      end
    end
  end

  assign qp.head = (cnt_r != 2'h0) ? mem[rd_ptr_r] : 11'h000;
  assign qp.full = (cnt_r == URXQ_DEPTH_CNT);
  assign qp.empty = (cnt_r == 2'h0);
  assign qp.cnt = cnt_r;
endmodule

//--- core/urxq_top.sv
// Serial receiver channel with holding queue, status, flow control and wake-up.
`timescale 1ns/10ps
module urxq_top (
  // Clock, reset and enable.
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Host bus pins.
  input wire logic [3:0] addr_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // Serial line and 16x bit clock pins.
  input wire logic rxd_i,
  input wire logic rx_clk16_i,
  // Output port bit that asserts request-to-send.
  input wire logic port_rts_i,
  // Channel outputs.
  output logic request_send_out_n_o,
  output logic rx_int_o,
  output logic tx_parity_append_o,
  output logic tx_parity_bit_o
);
  import urxq_pkg::*;

  urxq_q_if qi ();

  urxq_fifo u_fifo (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .qp(qi.q)
  );

  function automatic logic [2:0] char_bits(input logic [1:0] len);
    char_bits = URXQ_LEN_BASE + {1'b0, len};
  endfunction

  // Pin synchronisers.
  logic [14:0] bus_s1_r;
  logic [14:0] bus_s2_r;
  logic [14:0] bus_p_r;
  logic [1:0] ln_s1_r;
  logic [1:0] ln_s2_r;
  logic clk16_p_r;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_s1_r <= 15'h7000;
      bus_s2_r <= 15'h7000;
      bus_p_r <= 15'h7000;
      ln_s1_r <= 2'h1;
      ln_s2_r <= 2'h1;
      clk16_p_r <= 1'b0;
    end else if (ce_i) begin
      bus_s1_r <= {cs_n_i, rd_n_i, wr_n_i, addr_i, data_i};
      bus_s2_r <= bus_s1_r;
      bus_p_r <= bus_s2_r;
      ln_s1_r <= {rx_clk16_i, rxd_i};
      ln_s2_r <= ln_s1_r;
      clk16_p_r <= ln_s2_r[1];
    end
  end

  logic rxd;
  logic tick;
  logic rd_act;
  logic wr_act;
  logic rd_act_p;
  logic wr_act_p;
  logic rd_start;
  logic rd_end;
  logic wr_end;
  logic [3:0] addr_p;
  logic [7:0] wdata_p;

  assign rxd = ln_s2_r[0];
  assign tick = ln_s2_r[1] && !clk16_p_r;
  assign rd_act = !bus_s2_r[14] && !bus_s2_r[13];
  assign wr_act = !bus_s2_r[14] && !bus_s2_r[12];
  assign rd_act_p = !bus_p_r[14] && !bus_p_r[13];
  assign wr_act_p = !bus_p_r[14] && !bus_p_r[12];
  assign rd_start = rd_act && !rd_act_p;
  assign rd_end = rd_act_p && !rd_act;
  assign wr_end = wr_act_p && !wr_act;
  assign addr_p = bus_p_r[11:8];
  assign wdata_p = bus_p_r[7:0];

  // Mode register and its access pointer.
  logic [7:0] mr1_r;
  logic ptr_first_r;
  logic [3:0] rd_addr_r;
  logic [2:0] misc;
  logic cmd_wr;

  assign cmd_wr = wr_end && (addr_p == URXQ_ADDR_CMD);
  assign misc = wdata_p[URXQ_CMD_MISC_HI:URXQ_CMD_MISC_LO];

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mr1_r <= URXQ_MR_RESET;
      ptr_first_r <= 1'b1;
    end else if (ce_i) begin
      if (cmd_wr && misc == URXQ_MISC_RST_PTR) begin
        ptr_first_r <= 1'b1;
      end else if ((rd_end && rd_addr_r == URXQ_ADDR_MODE) ||
                   (wr_end && addr_p == URXQ_ADDR_MODE)) begin
        ptr_first_r <= 1'b0;
      end
      if (wr_end && addr_p == URXQ_ADDR_MODE && ptr_first_r) begin
        mr1_r <= wdata_p;
      end
    end
  end

  logic [1:0] pmode;
  logic mdrop;
  logic has_par;
  logic [2:0] nbits;

  assign pmode = mr1_r[URXQ_MR_PMODE_HI:URXQ_MR_PMODE_LO];
  assign mdrop = (pmode == URXQ_PM_MDROP);
  assign has_par = (pmode != URXQ_PM_NONE);
  assign nbits = char_bits(mr1_r[URXQ_MR_LEN_HI:URXQ_MR_LEN_LO]);
  assign tx_parity_append_o = has_par;
  assign tx_parity_bit_o = mr1_r[URXQ_MR_PTYPE_BIT];

  // Receiver enable.
  logic rx_en_r;
  logic rx_rst;

  assign rx_rst = cmd_wr && (misc == URXQ_MISC_RST_RX);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_en_r <= 1'b0;
    end else if (ce_i) begin
      if (rx_rst) begin
        rx_en_r <= 1'b0;
      end else if (cmd_wr && wdata_p[URXQ_CMD_RXDIS_BIT]) begin
        rx_en_r <= 1'b0;
      end else if (cmd_wr && wdata_p[URXQ_CMD_RXEN_BIT]) begin
        rx_en_r <= 1'b1;
      end
    end
  end

  // Bit-level receive state machine.
  urxq_state_t st_r;
  logic [3:0] cnt_r;
  logic [2:0] bitn_r;
  logic [7:0] shf_r;
  logic par_r;
  logic start_ok;
  logic done;
  logic sample;

  assign sample = (cnt_r == URXQ_BIT_TICKS);
  assign start_ok = tick && (st_r == URXQ_START) && !rxd &&
                    (cnt_r == URXQ_HALF_TICKS - 4'h1);
  assign done = tick && (st_r == URXQ_STOP) && sample;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= URXQ_IDLE;
      cnt_r <= 4'h0;
      bitn_r <= 3'h0;
      shf_r <= 8'h00;
      par_r <= 1'b0;
    end else if (ce_i) begin
      if (rx_rst) begin
        st_r <= URXQ_IDLE;
        cnt_r <= 4'h0;
      end else if (tick) begin
        case (st_r)
          URXQ_IDLE: begin
            cnt_r <= 4'h0;
            if ((rx_en_r || mdrop) && !rxd) begin
              st_r <= URXQ_START;
            end
          end
          URXQ_START: begin
            cnt_r <= cnt_r + 4'h1;
            if (rxd) begin
              st_r <= URXQ_IDLE;
            end else if (start_ok) begin
              st_r <= URXQ_DATA;
              cnt_r <= 4'h0;
              bitn_r <= 3'h0;
              shf_r <= 8'h00;
              par_r <= 1'b0;
            end
          end
          URXQ_DATA: begin
            cnt_r <= cnt_r + 4'h1;
            if (sample) begin
              shf_r[bitn_r] <= rxd;
              bitn_r <= bitn_r + 3'h1;
              if (bitn_r == nbits - 3'h1) begin
                st_r <= has_par ? URXQ_PAR : URXQ_STOP;
              end
            end
          end
          URXQ_PAR: begin
            cnt_r <= cnt_r + 4'h1;
            if (sample) begin
              par_r <= rxd;
              st_r <= URXQ_STOP;
            end
          end
          URXQ_STOP: begin
            cnt_r <= cnt_r + 4'h1;
            if (sample) begin
              cnt_r <= 4'h0;
              if (rxd) begin
                st_r <= URXQ_IDLE;
              end else if (shf_r == 8'h00 && !par_r) begin
                st_r <= URXQ_BRKW;
              end else begin
                st_r <= URXQ_FEW;
              end
            end
          end
          URXQ_BRKW: begin
            cnt_r <= rxd ? cnt_r + 4'h1 : 4'h0;
            if (rxd && cnt_r == URXQ_HALF_TICKS - 4'h1) begin
              st_r <= URXQ_IDLE;
            end
          end
          URXQ_FEW: begin
            cnt_r <= cnt_r + 4'h1;
            if (rxd) begin
              st_r <= URXQ_IDLE;
            end else if (cnt_r == URXQ_HALF_TICKS - 4'h1) begin
              st_r <= URXQ_START;
              cnt_r <= 4'h0;
            end
          end
          default: begin
            st_r <= URXQ_IDLE;
            cnt_r <= 4'h0;
          end
        endcase
      end
    end
  end

  // Character completion: tags and acceptance.
  logic c_brk;
  logic c_frm;
  logic c_perr;
  logic accept;
  logic [10:0] c_entry;

  assign c_frm = !rxd;
  assign c_brk = !rxd && (shf_r == 8'h00) && !par_r;
  always_comb begin
    case (pmode)
      URXQ_PM_WITH: c_perr = (^shf_r) ^ par_r ^ mr1_r[URXQ_MR_PTYPE_BIT];
      URXQ_PM_FORCE: c_perr = par_r ^ mr1_r[URXQ_MR_PTYPE_BIT];
      URXQ_PM_MDROP: c_perr = par_r;
      default: c_perr = 1'b0;
    endcase
  end
  assign accept = done && (rx_en_r || (mdrop && par_r));
  assign c_entry = {c_brk, c_frm, c_perr, shf_r};

  // Shift-register hold while the queue is full, and overrun.
  logic [10:0] held_r;
  logic held_v_r;
  logic ovr_r;
  logic rst_err;

  assign rst_err = cmd_wr && (misc == URXQ_MISC_RST_ERR);
  assign qi.clr = rx_rst;
  assign qi.push = !rx_rst && ((held_v_r && !qi.full) || (accept && !qi.full));
  assign qi.push_data = held_v_r ? held_r : c_entry;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      held_r <= 11'h000;
      held_v_r <= 1'b0;
    end else if (ce_i) begin
      if (rx_rst) begin
        held_v_r <= 1'b0;
      end else if (accept && (qi.full || held_v_r)) begin
        held_r <= c_entry;
        held_v_r <= 1'b1;
      end else if (start_ok && held_v_r) begin
        held_v_r <= 1'b0;
      end else if (held_v_r && !qi.full) begin
        held_v_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ovr_r <= 1'b0;
    end else if (ce_i) begin
      if (rx_rst) begin
        ovr_r <= 1'b0;
      end else if (start_ok && held_v_r && qi.full) begin
        ovr_r <= 1'b1;
      end else if (rst_err) begin
        ovr_r <= 1'b0;
      end
    end
  end

  // Flow control of request-to-send.
  logic rts_neg_r;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rts_neg_r <= 1'b0;
    end else if (ce_i) begin
      if (rx_rst) begin
        rts_neg_r <= 1'b0;
      end else if (start_ok && qi.full && mr1_r[URXQ_MR_RTS_BIT]) begin
        rts_neg_r <= 1'b1;
      end else if (!qi.full) begin
        rts_neg_r <= 1'b0;
      end
    end
  end

  assign request_send_out_n_o = !(port_rts_i && !rts_neg_r);

  // Block-mode accumulation of tags reaching the head.
  logic head_new_r;
  logic [2:0] acc_r;
  logic pop;
  logic [2:0] head_tags;

  assign pop = rd_end && (rd_addr_r == URXQ_ADDR_HOLD) && !qi.empty;
  assign qi.pop = pop && !rx_rst;
  assign head_tags = qi.empty ? 3'h0 : qi.head[10:8];

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      head_new_r <= 1'b0;
      acc_r <= 3'h0;
    end else if (ce_i) begin
      head_new_r <= (qi.push && qi.empty) || (qi.pop && qi.cnt > 2'h1);
      if (rx_rst) begin
        acc_r <= 3'h0;
      end else if (head_new_r) begin
        acc_r <= (rst_err ? 3'h0 : acc_r) | head_tags;
      end else if (rst_err) begin
        acc_r <= 3'h0;
      end
    end
  end

  logic [7:0] status;
  logic [2:0] shown_tags;

  assign shown_tags = mr1_r[URXQ_MR_ERRMODE_BIT] ? (acc_r | head_tags) : head_tags;
  always_comb begin
    status = 8'h00;
    status[URXQ_STAT_BRK_BIT] = shown_tags[2];
    status[URXQ_STAT_FRM_BIT] = shown_tags[1];
    status[URXQ_STAT_PERR_BIT] = shown_tags[0];
    status[URXQ_STAT_OVR_BIT] = ovr_r;
    status[URXQ_STAT_FULL_BIT] = qi.full;
    status[URXQ_STAT_RDY_BIT] = !qi.empty;
  end

  assign rx_int_o = mr1_r[URXQ_MR_INTSEL_BIT] ? qi.full : !qi.empty;

  // Read data path.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_o <= 8'h00;
      data_oe_o <= 1'b0;
      rd_addr_r <= 4'h0;
    end else if (ce_i) begin
      if (rd_start) begin
        data_oe_o <= 1'b1;
        rd_addr_r <= bus_s2_r[11:8];
        case (bus_s2_r[11:8])
          URXQ_ADDR_MODE: data_o <= ptr_first_r ? mr1_r : 8'h00;
          URXQ_ADDR_STATUS: data_o <= status;
          URXQ_ADDR_HOLD: data_o <= qi.head[7:0];
          default: data_o <= 8'h00;
        endcase
      end else if (rd_end) begin
        data_oe_o <= 1'b0;
      end
    end
  end
endmodule

//--- testbench/urxq_top_chk.sv
// Concurrent checks on the pins of the receive channel.
`timescale 1ns/10ps
module urxq_top_chk (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Host and line pins.
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic rxd_i,
  input wire logic port_rts_i,
  // Channel outputs.
  input wire logic [7:0] data_o,
  input wire logic data_oe_o,
  input wire logic request_send_out_n_o,
  input wire logic rx_int_o,
  input wire logic tx_parity_append_o,
  input wire logic tx_parity_bit_o
);
  logic [7:0] cs_age_r;
  logic [9:0] low_age_r;
  logic rd_pin;
  assign rd_pin = !cs_n_i && !rd_n_i;
  // Cycles since chip select was last low, saturating.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      cs_age_r <= 8'hFF;
    else if (!cs_n_i)
      cs_age_r <= 8'h00;
    else if (cs_age_r != 8'hFF)
      cs_age_r <= cs_age_r + 8'h01;
  end
  // Cycles since the serial line was last low, saturating.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      low_age_r <= 10'h3FF;
    else if (!rxd_i)
      low_age_r <= 10'h000;
    else if (low_age_r != 10'h3FF)
      low_age_r <= low_age_r + 10'h001;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  chk_rts_gate: assert property (!port_rts_i |-> request_send_out_n_o)
    else $error("request output asserted without port bit");
  chk_rts_negate: assert property ($rose(request_send_out_n_o) && port_rts_i &&
    $past(port_rts_i) |-> low_age_r < 10'h008)
    else $error("request negated without a start bit");
  chk_rts_restore: assert property ($fell(request_send_out_n_o) && port_rts_i &&
    $past(port_rts_i) |-> cs_age_r < 8'h0C)
    else $error("request restored without a host access");
  chk_oe_answer: assert property (rd_pin [*4] |=> data_oe_o)
    else $error("read strobe not answered");
  chk_oe_release: assert property ((!rd_pin) [*4] |=> !data_oe_o)
    else $error("data bus driven after strobe end");
  chk_data_hold: assert property (!$stable(data_o) |-> $past(rd_pin, 3))
    else $error("read data changed outside a read");
  chk_int_fall: assert property ($fell(rx_int_o) |-> cs_age_r < 8'h0C)
    else $error("receive interrupt dropped without a host access");
  chk_int_rise: assert property ($rose(rx_int_o) |->
    low_age_r < 10'h3E8 || cs_age_r < 8'h0C)
    else $error("receive interrupt raised without a character");
  chk_tx_mode: assert property (!$stable({tx_parity_append_o, tx_parity_bit_o}) |->
    cs_age_r < 8'h0C)
    else $error("parity outputs changed without a write");
endmodule

//--- testbench/urxq_line_model.sv
// Remote serial transmitter and 16x bit clock for the receive channel.
`timescale 1ns/10ps
module urxq_line_model (
  // Reference clock.
  input wire logic ref_clk_i,
  // Line side.
  output logic rxd_o,
  output logic clk16_o
);
  initial begin
    rxd_o = 1'b1;
    clk16_o = 1'b0;
  end
  // The bit clock runs free because the receiver counts idle ticks.
  always begin
    repeat (2) @(negedge ref_clk_i);
    clk16_o = ~clk16_o;
  end
  task automatic hold_bit(input logic v, input int ticks);
    rxd_o = v;
    repeat (ticks) @(posedge clk16_o);
  endtask
  // Start, data LSB first, optional parity or tag, stop, then idle mark.
  task automatic send(input logic [7:0] d, input int n, input logic has_par,
                      input logic par, input logic stop, input int idle);
    hold_bit(1'b0, 16);
    for (int i = 0; i < n; i++) hold_bit(d[i], 16);
    if (has_par) hold_bit(par, 16);
    hold_bit(stop, 16);
    if (idle > 0) hold_bit(1'b1, idle);
  endtask
endmodule

//--- testbench/urxq_bench.sv
// Self-checking bench for the receive queue channel.
`timescale 1ns/10ps
module urxq_bench;
  import urxq_pkg::*;
  logic clk, nrst, cs_n, rd_n, wr_n, port_rts, oe, rxd, clk16, rts_n, rx_int, tx_app, tx_par;
  logic [3:0] addr;
  logic [7:0] wdata, dout, rdata;
  int n_fail, samples_checked, cyc;
  initial clk = 1'b0;
  always #10 clk = ~clk;
  urxq_top u_urxq_top (.ref_clk_i(clk), .nrst_i(nrst), .ce_i(1'b1), .addr_i(addr),
    .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .data_i(wdata), .data_o(dout),
    .data_oe_o(oe), .rxd_i(rxd), .rx_clk16_i(clk16), .port_rts_i(port_rts),
    .request_send_out_n_o(rts_n), .rx_int_o(rx_int), .tx_parity_append_o(tx_app),
    .tx_parity_bit_o(tx_par));
  urxq_line_model u_urxq_line_model (.ref_clk_i(clk), .rxd_o(rxd), .clk16_o(clk16));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic [3:0] a, input logic wr, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    cs_n = 1'b0;
    rd_n = wr;
    wr_n = !wr;
    repeat (5) @(negedge clk);
    rdata = dout;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    bus(a, 1'b0, 8'h00);
    check(rdata, exp);
  endtask
  task automatic tx(input logic [7:0] d, input int n, input logic hp, input logic p,
                    input logic st, input int idle);
    u_urxq_line_model.send(d, n, hp, p, st, idle);
    repeat (8) @(negedge clk);
  endtask
  // Mode changes are made with the receiver disabled and the pointer reset.
  task automatic set_mode(input logic [7:0] m);
    wr(URXQ_ADDR_CMD, 8'h12);
    wr(URXQ_ADDR_MODE, m);
  endtask
  always @(negedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      print_verdict;
    end
  end
  initial begin
    nrst = 1'b0;
    {cs_n, rd_n, wr_n} = 3'h7;
    addr = 4'h0;
    wdata = 8'h00;
    port_rts = 1'b0;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    rd_chk(URXQ_ADDR_MODE, URXQ_MR_RESET);
    wr(URXQ_ADDR_CMD, 8'h10);
    wr(URXQ_ADDR_MODE, 8'hA5);
    rd_chk(URXQ_ADDR_MODE, 8'h00);
    wr(URXQ_ADDR_CMD, 8'h10);
    rd_chk(URXQ_ADDR_MODE, 8'hA5);
    rd_chk(4'h4, 8'h00);
    check({6'h00, tx_app, tx_par}, 8'h03);
    $display("test pointer done");
    port_rts = 1'b1;
    set_mode(8'hD3);
    wr(URXQ_ADDR_CMD, 8'h01);
    tx(8'h11, 8, 1'b0, 1'b0, 1'b1, 16);
    tx(8'h22, 8, 1'b0, 1'b0, 1'b1, 16);
    check({7'h00, rx_int}, 8'h00);
    rd_chk(URXQ_ADDR_STATUS, 8'h01);
    tx(8'h33, 8, 1'b0, 1'b0, 1'b1, 16);
    check({7'h00, rx_int}, 8'h01);
    rd_chk(URXQ_ADDR_STATUS, 8'h03);
    rd_chk(URXQ_ADDR_STATUS, 8'h03);
    tx(8'h44, 8, 1'b0, 1'b0, 1'b1, 16);
    check({7'h00, rts_n}, 8'h01);
    tx(8'h55, 8, 1'b0, 1'b0, 1'b1, 16);
    rd_chk(URXQ_ADDR_STATUS, 8'h13);
    rd_chk(URXQ_ADDR_HOLD, 8'h11);
    check({7'h00, rts_n}, 8'h00);
    rd_chk(URXQ_ADDR_STATUS, 8'h13);
    rd_chk(URXQ_ADDR_HOLD, 8'h22);
    rd_chk(URXQ_ADDR_HOLD, 8'h33);
    rd_chk(URXQ_ADDR_HOLD, 8'h55);
    rd_chk(URXQ_ADDR_STATUS, 8'h10);
    wr(URXQ_ADDR_CMD, 8'h40);
    rd_chk(URXQ_ADDR_STATUS, 8'h00);
    $display("test queue done");
    set_mode(8'h22);
    wr(URXQ_ADDR_CMD, 8'h01);
    tx(8'h55, 7, 1'b1, 1'b1, 1'b1, 16);
    check({7'h00, rx_int}, 8'h01);
    rd_chk(URXQ_ADDR_STATUS, 8'h21);
    rd_chk(URXQ_ADDR_HOLD, 8'h55);
    rd_chk(URXQ_ADDR_STATUS, 8'h20);
    wr(URXQ_ADDR_CMD, 8'h40);
    rd_chk(URXQ_ADDR_STATUS, 8'h00);
    tx(8'hFF, 7, 1'b1, 1'b1, 1'b1, 16);
    rd_chk(URXQ_ADDR_HOLD, 8'h7F);
    tx(8'h41, 7, 1'b1, 1'b0, 1'b0, 0);
    tx(8'h06, 7, 1'b1, 1'b0, 1'b1, 16);
    rd_chk(URXQ_ADDR_STATUS, 8'h41);
    rd_chk(URXQ_ADDR_HOLD, 8'h41);
    rd_chk(URXQ_ADDR_HOLD, 8'h06);
    wr(URXQ_ADDR_CMD, 8'h40);
    tx(8'h00, 7, 1'b1, 1'b0, 1'b0, 16);
    bus(URXQ_ADDR_STATUS, 1'b0, 8'h00);
    check(rdata & 8'h81, 8'h81);
    rd_chk(URXQ_ADDR_HOLD, 8'h00);
    wr(URXQ_ADDR_CMD, 8'h40);
    $display("test errors done");
    tx(8'h5A, 7, 1'b1, 1'b0, 1'b1, 16);
    wr(URXQ_ADDR_CMD, 8'h02);
    tx(8'h21, 7, 1'b1, 1'b0, 1'b1, 16);
    rd_chk(URXQ_ADDR_STATUS, 8'h01);
    rd_chk(URXQ_ADDR_HOLD, 8'h5A);
    wr(URXQ_ADDR_CMD, 8'h01);
    tx(8'h21, 7, 1'b1, 1'b0, 1'b1, 16);
    wr(URXQ_ADDR_CMD, 8'h20);
    rd_chk(URXQ_ADDR_STATUS, 8'h00);
    tx(8'h21, 7, 1'b1, 1'b0, 1'b1, 16);
    rd_chk(URXQ_ADDR_STATUS, 8'h00);
    rd_chk(URXQ_ADDR_HOLD, 8'h00);
    $display("test enable done");
    set_mode(8'h1B);
    check({6'h00, tx_app, tx_par}, 8'h02);
    tx(8'h33, 8, 1'b1, 1'b0, 1'b1, 16);
    rd_chk(URXQ_ADDR_STATUS, 8'h00);
    tx(8'h77, 8, 1'b1, 1'b1, 1'b1, 16);
    rd_chk(URXQ_ADDR_STATUS, 8'h21);
    rd_chk(URXQ_ADDR_HOLD, 8'h77);
    wr(URXQ_ADDR_CMD, 8'h01);
    tx(8'h12, 8, 1'b1, 1'b0, 1'b1, 16);
    rd_chk(URXQ_ADDR_STATUS, 8'h01);
    rd_chk(URXQ_ADDR_HOLD, 8'h12);
    $display("test multidrop done");
    set_mode(8'h0C);
    wr(URXQ_ADDR_CMD, 8'h01);
    check({6'h00, tx_app, tx_par}, 8'h03);
    tx(8'h15, 5, 1'b1, 1'b1, 1'b1, 16);
    tx(8'h0A, 5, 1'b1, 1'b0, 1'b1, 16);
    rd_chk(URXQ_ADDR_STATUS, 8'h01);
    rd_chk(URXQ_ADDR_HOLD, 8'h15);
    rd_chk(URXQ_ADDR_STATUS, 8'h21);
    rd_chk(URXQ_ADDR_HOLD, 8'h0A);
    $display("test forced parity done");
    print_verdict;
  end
endmodule
bind urxq_top urxq_top_chk u_urxq_top_chk (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
  .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .rxd_i(rxd_i), .port_rts_i(port_rts_i),
  .data_o(data_o), .data_oe_o(data_oe_o), .request_send_out_n_o(request_send_out_n_o),
  .rx_int_o(rx_int_o), .tx_parity_append_o(tx_parity_append_o),
  .tx_parity_bit_o(tx_parity_bit_o));
